// File: rtl/crb_pkg.sv
// constants, field layouts and types for the capture/reload/baud timer
// assumes a byte-wide special-function register port and one system clock
`default_nettype none
package crb_pkg;
   // register addresses on the special-function port
   localparam logic [7:0] ADDR_CONTROL   = 8'hC9;
   localparam logic [7:0] ADDR_CAP_LOW   = 8'hE4;
   localparam logic [7:0] ADDR_CAP_HIGH  = 8'hE5;
   localparam logic [7:0] ADDR_CNT_LOW   = 8'hF4;
   localparam logic [7:0] ADDR_CNT_HIGH  = 8'hF5;
   // reset values and the all-ones rollover value
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] RELOAD_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   // control field positions
   localparam int BIT_OVERFLOW_FLAG = 7;
   localparam int BIT_EXTERNAL_FLAG = 6;
   localparam int BIT_RX_SELECT     = 5;
   localparam int BIT_TX_SELECT     = 4;
   localparam int BIT_TRIGGER_EN    = 3;
   localparam int BIT_RUN           = 2;
   localparam int BIT_COUNTER_SEL   = 1;
   localparam int BIT_CAPTURE_SEL   = 0;
   // timebase division counts
   localparam logic [3:0] DIV_FAST = 4'h1;
   localparam logic [3:0] DIV_BAUD = 4'h2;
   localparam logic [3:0] DIV_SLOW = 4'hC;
   // control register layout, most significant field first
   typedef struct packed {
      logic overflow_flag;
      logic external_flag;
      logic uart_rx_clock_select;
      logic uart_tx_clock_select;
      logic trigger_enable;
      logic run_bit;
      logic counter_select;
      logic capture_select;
   } crb_ctrl_t;
   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } crb_sfr_req_t;
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_CAPTURE,
      MODE_RELOAD,
      MODE_BAUD
   } crb_mode_t;
endpackage
`default_nettype wire

// File: rtl/crb_edge_sync.sv
// two-stage synchroniser with falling-edge detect for one input pin
// assumes the pin may change at any time relative to ref_clk
`default_nettype none
module crb_edge_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // pin and edge
   input  wire logic pin,
   output logic      fall
);
   logic meta;
   logic stable;
   logic previous;

   // first stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta   <= 1'b1;
         stable <= 1'b1;
      end else begin
         meta   <= pin;
         stable <= meta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         previous <= 1'b1;
      end else begin
         previous <= stable;
      end
   end

   // high then low on successive samples
   assign fall = previous & ~stable; // RQ20
endmodule
`default_nettype wire

// File: rtl/crb_timer.sv
// capture/reload/baud 16-bit timer with its special-function registers
// assumes synchronous register strobes, pins resynchronised here
// Function
// RQ1 - 16-bit counter, two software-accessible bytes
// RQ2 - timer mode counts system clock /1 or /12
// RQ3 - counter mode counts count-pin falling edges
// RQ4 - mode chosen by capture, run, clock-select bits
// RQ5 - trigger edge captures count, sets external flag
// RQ6 - trigger disabled ignores trigger pin
// RQ7 - rollover sets overflow flag in bit 7
// RQ8 - auto-reload loads reload value on overflow
// RQ9 - trigger edge reloads, sets external flag
// RQ10 - any clock-select bit gives baud reload mode
// RQ11 - baud overflows tick uart, not flag
// RQ12 - baud timer mode counts at half clock
// RQ13 - baud counter mode counts pin edges
// RQ14 - baud trigger edge sets external flag
// RQ15 - receive select picks uart receive tick source
// RQ16 - transmit select picks uart transmit tick source
// RQ17 - flags cleared only by software writes
// RQ18 - enabled set flag raises interrupt request
// RQ19 - run bit zero holds counter
// RQ20 - pins synchronised, falling edge by sample compare
`default_nettype none
module crb_timer
   import crb_pkg::*;
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          reset,
   // special-function register port
   input  wire crb_pkg::crb_sfr_req_t sfr_req,
   output logic [7:0]         sfr_rdata,
   // clock control bit held outside
   input  wire logic          prescale_select,
   // pins
   input  wire logic          count_input_pin,
   input  wire logic          trigger_input_pin,
   // interrupt
   input  wire logic          irq_enable,
   output logic               irq_req,
   // uart shift clocks
   input  wire logic          general_timer_ovf,
   output logic               uart_rx_tick,
   output logic               uart_tx_tick
);
   import crb_pkg::*;

   crb_ctrl_t  ctrl;
   crb_ctrl_t  next_ctrl;
   crb_mode_t  mode;
   logic [15:0] count;
   logic [15:0] reload;
   logic [3:0]  presc;
   logic [3:0]  div_limit;
   logic        presc_hit;
   logic        count_fall;
   logic        trigger_fall;
   logic        tick;
   logic        overflow;
   logic        trigger;
   logic        own_baud_tick;
   logic        wr_ctrl;
   logic        wr_cnt_low;
   logic        wr_cnt_high;
   logic        wr_cap_low;
   logic        wr_cap_high;

   function automatic logic [7:0] read_mux(input logic [7:0] a, input crb_ctrl_t c,
                                           input logic [15:0] cnt, input logic [15:0] rl);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         ADDR_CONTROL:  v = c;
         ADDR_CAP_LOW:  v = rl[7:0];
         ADDR_CAP_HIGH: v = rl[15:8];
         ADDR_CNT_LOW:  v = cnt[7:0];
         ADDR_CNT_HIGH: v = cnt[15:8];
         default:       v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic hit(input crb_sfr_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // pin synchronisers
   crb_edge_sync u_count_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .pin     (count_input_pin),
      .fall    (count_fall)
   );
   crb_edge_sync u_trigger_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .pin     (trigger_input_pin),
      .fall    (trigger_fall)
   );

   // write decode
   assign wr_ctrl     = hit(sfr_req, ADDR_CONTROL);
   assign wr_cnt_low  = hit(sfr_req, ADDR_CNT_LOW);
   assign wr_cnt_high = hit(sfr_req, ADDR_CNT_HIGH);
   assign wr_cap_low  = hit(sfr_req, ADDR_CAP_LOW);
   assign wr_cap_high = hit(sfr_req, ADDR_CAP_HIGH);

   // mode select
   always_comb begin
      if (!ctrl.run_bit) begin
         mode = MODE_OFF; // RQ19
      end else if (ctrl.uart_rx_clock_select || ctrl.uart_tx_clock_select) begin
         mode = MODE_BAUD; // RQ10
      end else if (ctrl.capture_select) begin
         mode = MODE_CAPTURE; // RQ4
      end else begin
         mode = MODE_RELOAD; // RQ4
      end
   end

   // timebase prescaler
   always_comb begin
      if (mode == MODE_BAUD) begin
         div_limit = DIV_BAUD; // RQ12
      end else if (prescale_select) begin
         div_limit = DIV_FAST; // RQ2
      end else begin
         div_limit = DIV_SLOW; // RQ2
      end
   end

   // a limit lowered mid-count must not wrap the prescaler through its full range
   assign presc_hit = (presc >= div_limit - 4'h1);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         presc <= 4'h0;
      end else if (mode == MODE_OFF || ctrl.counter_select || presc_hit) begin
         presc <= 4'h0;
      end else begin
         presc <= presc + 4'h1;
      end
   end

   // count enable: prescaled clock or pin edge
   assign tick = (mode != MODE_OFF) &&
                 (ctrl.counter_select ? count_fall : presc_hit); // RQ3 RQ13 RQ19
   assign overflow = tick && (count == COUNT_ALL_ONES);
   assign trigger  = trigger_fall && ctrl.trigger_enable && (mode != MODE_OFF); // RQ6
   assign own_baud_tick = overflow && (mode == MODE_BAUD); // RQ11

   // counter
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count <= COUNT_RESET;
      end else if (wr_cnt_low || wr_cnt_high) begin
         if (wr_cnt_low) begin
            count[7:0] <= sfr_req.wdata; // RQ1
         end
         if (wr_cnt_high) begin
            count[15:8] <= sfr_req.wdata; // RQ1
         end
      end else if (mode != MODE_CAPTURE && mode != MODE_OFF && (overflow || trigger)) begin
         count <= reload; // RQ8 RQ9 RQ10
      end else if (tick) begin
         count <= count + 16'h0001; // RQ1
      end
   end

   // capture/reload value
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reload <= RELOAD_RESET;
      end else if (mode == MODE_CAPTURE && trigger) begin
         reload <= count; // RQ5
      end else begin
         if (wr_cap_low) begin
            reload[7:0] <= sfr_req.wdata;
         end
         if (wr_cap_high) begin
            reload[15:8] <= sfr_req.wdata;
         end
      end
   end

   // control register, hardware set wins over software clear
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = crb_ctrl_t'(sfr_req.wdata); // RQ17
      end
      if (overflow && (mode == MODE_CAPTURE || mode == MODE_RELOAD)) begin
         next_ctrl.overflow_flag = 1'b1; // RQ7
      end
      if (trigger) begin
         next_ctrl.external_flag = 1'b1; // RQ5 RQ9 RQ14
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl <= crb_ctrl_t'(CONTROL_RESET);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // interrupt request
   assign irq_req = irq_enable && (ctrl.overflow_flag || ctrl.external_flag); // RQ18

   // uart shift clock ticks
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         uart_rx_tick <= 1'b0;
         uart_tx_tick <= 1'b0;
      end else begin
         uart_rx_tick <= ctrl.uart_rx_clock_select ? own_baud_tick : general_timer_ovf; // RQ15
         uart_tx_tick <= ctrl.uart_tx_clock_select ? own_baud_tick : general_timer_ovf; // RQ16
      end
   end

   // read data
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         sfr_rdata <= read_mux(sfr_req.addr, ctrl, count, reload);
      end
   end

   // checks
   property p_overflow_flag;
      @(posedge ref_clk) disable iff (reset)
      (overflow && (mode == MODE_CAPTURE || mode == MODE_RELOAD)) |=> ctrl.overflow_flag;
   endproperty
   a_overflow_flag: assert property (p_overflow_flag) // RQ7
      else $error("overflow flag not set on rollover");

   property p_baud_no_flag;
      @(posedge ref_clk) disable iff (reset)
      (mode == MODE_BAUD && !wr_ctrl && !ctrl.overflow_flag) |=> !ctrl.overflow_flag;
   endproperty
   a_baud_no_flag: assert property (p_baud_no_flag) // RQ11
      else $error("overflow flag set in baud mode");

   property p_reload_on_overflow;
      @(posedge ref_clk) disable iff (reset)
      (overflow && mode == MODE_RELOAD && !wr_cnt_low && !wr_cnt_high)
         |=> count == $past(reload);
   endproperty
   a_reload_on_overflow: assert property (p_reload_on_overflow) // RQ8
      else $error("counter not reloaded on overflow");

   property p_capture;
      @(posedge ref_clk) disable iff (reset)
      (trigger && mode == MODE_CAPTURE) |=> (reload == $past(count)) && ctrl.external_flag;
   endproperty
   a_capture: assert property (p_capture) // RQ5
      else $error("capture did not copy count");

   property p_trigger_ignored;
      @(posedge ref_clk) disable iff (reset)
      (!ctrl.trigger_enable && !wr_ctrl && !ctrl.external_flag) |=> !ctrl.external_flag;
   endproperty
   a_trigger_ignored: assert property (p_trigger_ignored) // RQ6
      else $error("external flag set while trigger disabled");

   property p_run_hold;
      @(posedge ref_clk) disable iff (reset)
      (!ctrl.run_bit && !wr_cnt_low && !wr_cnt_high) |=> $stable(count);
   endproperty
   a_run_hold: assert property (p_run_hold) // RQ19
      else $error("counter moved while stopped");

   property p_flag_sticky;
      @(posedge ref_clk) disable iff (reset)
      (ctrl.overflow_flag && !wr_ctrl) |=> ctrl.overflow_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // RQ17
      else $error("overflow flag cleared by hardware");

   property p_irq;
      @(posedge ref_clk) disable iff (reset)
      (irq_enable && ctrl.external_flag) |-> irq_req;
   endproperty
   a_irq: assert property (p_irq) // RQ18
      else $error("interrupt not raised for set flag");

   property p_baud_half;
      @(posedge ref_clk) disable iff (reset)
      (mode == MODE_BAUD && !ctrl.counter_select && tick)
         ##1 (mode == MODE_BAUD && !ctrl.counter_select) |-> !tick;
   endproperty
   a_baud_half: assert property (p_baud_half) // RQ12
      else $error("baud timebase faster than half clock");

   property p_rx_tick;
      @(posedge ref_clk) disable iff (reset)
      (own_baud_tick && ctrl.uart_rx_clock_select) |=> uart_rx_tick;
   endproperty
   a_rx_tick: assert property (p_rx_tick) // RQ15
      else $error("receive tick missing");

   property p_tx_tick;
      @(posedge ref_clk) disable iff (reset)
      (own_baud_tick && ctrl.uart_tx_clock_select) |=> uart_tx_tick;
   endproperty
   a_tx_tick: assert property (p_tx_tick) // RQ16
      else $error("transmit tick missing");

   property p_general_rx;
      @(posedge ref_clk) disable iff (reset)
      !ctrl.uart_rx_clock_select |=> (uart_rx_tick == $past(general_timer_ovf));
   endproperty
   a_general_rx: assert property (p_general_rx) // RQ15
      else $error("receive tick not from general timer");

   property p_general_tx;
      @(posedge ref_clk) disable iff (reset)
      !ctrl.uart_tx_clock_select |=> (uart_tx_tick == $past(general_timer_ovf));
   endproperty
   a_general_tx: assert property (p_general_tx) // RQ16
      else $error("transmit tick not from general timer");

   property p_trigger_reload;
      @(posedge ref_clk) disable iff (reset)
      (trigger && mode == MODE_RELOAD && !wr_cnt_low && !wr_cnt_high)
         |=> (count == $past(reload)) && ctrl.external_flag;
   endproperty
   a_trigger_reload: assert property (p_trigger_reload) // RQ9
      else $error("trigger did not reload counter");

   property p_ext_sticky;
      @(posedge ref_clk) disable iff (reset)
      (ctrl.external_flag && !wr_ctrl) |=> ctrl.external_flag;
   endproperty
   a_ext_sticky: assert property (p_ext_sticky) // RQ17
      else $error("external flag cleared by hardware");

   property p_count_step;
      @(posedge ref_clk) disable iff (reset)
      (tick && !overflow && !trigger && !wr_cnt_low && !wr_cnt_high)
         |=> count == $past(count) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) // RQ1
      else $error("counter did not step by one");

   property p_fast_rate;
      @(posedge ref_clk) disable iff (reset)
      ((mode == MODE_CAPTURE || mode == MODE_RELOAD) && !ctrl.counter_select && prescale_select)
         |-> tick;
   endproperty
   a_fast_rate: assert property (p_fast_rate) // RQ2
      else $error("undivided timebase missed a cycle");

   property p_baud_ext;
      @(posedge ref_clk) disable iff (reset)
      (trigger && mode == MODE_BAUD) |=> ctrl.external_flag;
   endproperty
   a_baud_ext: assert property (p_baud_ext) // RQ14
      else $error("external flag not set in baud mode");
endmodule
`default_nettype wire

// File: dv/crb_far_side.sv
// far-side model: count and trigger pins, other timer overflow, uart tick counters
// assumes ref_clk is the system clock; pins idle high
`default_nettype none
module crb_far_side (
   // clock
   input  wire logic ref_clk,
   // pins and other timer overflow
   output logic      count_pin,
   output logic      trig_pin,
   output logic      gen_ovf,
   // uart ticks
   input  wire logic rx_tick,
   input  wire logic tx_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_seen = 8'h00;
   logic [7:0] tx_seen = 8'h00;
   initial begin
      count_pin = 1'b1;
      trig_pin  = 1'b1;
      gen_ovf   = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (rx_tick) rx_seen <= rx_seen + 8'h01;
      if (tx_tick) tx_seen <= tx_seen + 8'h01;
   end
   // pulses wide enough for the two-flop synchroniser
   task automatic fall(input logic trig, input int n);
      repeat (n) begin
         if (trig) trig_pin <= 1'b0;
         else count_pin <= 1'b0;
         repeat (4) @(posedge ref_clk);
         trig_pin  <= 1'b1;
         count_pin <= 1'b1;
         repeat (4) @(posedge ref_clk);
      end
   endtask
   task automatic ovf_pulse();
      gen_ovf <= 1'b1;
      @(posedge ref_clk);
      gen_ovf <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// File: dv/crb_timer_tb.sv
// self-checking bench for the capture/reload/baud timer
// assumes crb_pkg and crb_timer compiled first, far-side model beside it
`default_nettype none
module crb_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import crb_pkg::*;
   logic         ref_clk;
   logic         reset;
   crb_sfr_req_t sfr_req;
   logic [7:0]   sfr_rdata;
   logic         prescale_select;
   logic         count_input_pin;
   logic         trigger_input_pin;
   logic         irq_enable;
   logic         irq_req;
   logic         general_timer_ovf;
   logic         uart_rx_tick;
   logic         uart_tx_tick;
   int           mismatches = 0;
   int           num_checks = 0;
   int           cycles = 0;
   logic [7:0]   rx0;
   logic [7:0]   tx0;
   logic [7:0]   regs [5] = '{ADDR_CONTROL, ADDR_CAP_LOW, ADDR_CAP_HIGH, ADDR_CNT_LOW,
                              ADDR_CNT_HIGH};
   logic [7:0]   ctl [3]  = '{8'h04, 8'h04, 8'h34};
   logic         ps [3]   = '{1'b1, 1'b0, 1'b1};
   int           kk [3]   = '{48, 124, 99};
   logic [7:0]   ex [3]   = '{8'h32, 8'h0A, 8'h32};

   crb_timer u_crb_timer (.ref_clk(ref_clk), .reset(reset), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .prescale_select(prescale_select),
      .count_input_pin(count_input_pin), .trigger_input_pin(trigger_input_pin),
      .irq_enable(irq_enable), .irq_req(irq_req), .general_timer_ovf(general_timer_ovf),
      .uart_rx_tick(uart_rx_tick), .uart_tx_tick(uart_tx_tick));
   crb_far_side u_crb_far_side (.ref_clk(ref_clk), .count_pin(count_input_pin),
      .trig_pin(trigger_input_pin), .gen_ovf(general_timer_ovf),
      .rx_tick(uart_rx_tick), .tx_tick(uart_tx_tick));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req <= {1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      sfr_req <= '0;
      @(posedge ref_clk);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      sfr_req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk);
      sfr_req <= '0;
      @(posedge ref_clk);
      check8(n, e, sfr_rdata);
   endtask
   task automatic chk16(input string n, input logic [7:0] a, input logic [15:0] e);
      rchk(n, a, e[7:0]);
      rchk(n, a + 8'h01, e[15:8]);
   endtask
   task automatic setup(input logic [15:0] c, input logic [15:0] r, input logic [7:0] k);
      wr(ADDR_CNT_LOW, c[7:0]);
      wr(ADDR_CNT_HIGH, c[15:8]);
      wr(ADDR_CAP_LOW, r[7:0]);
      wr(ADDR_CAP_HIGH, r[15:8]);
      wr(ADDR_CONTROL, k);
   endtask

   initial begin
      reset = 1'b1;
      sfr_req = '0;
      prescale_select = 1'b1;
      irq_enable = 1'b0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      foreach (regs[i]) rchk("reset", regs[i], 8'h00);
      for (int i = 1; i < 5; i++) wr(regs[i], regs[i] ^ 8'h5A);
      wr(8'hC8, 8'hFF);
      repeat (20) @(posedge ref_clk);
      for (int i = 1; i < 5; i++) rchk("rw", regs[i], regs[i] ^ 8'h5A);
      rchk("unmapped", 8'hC8, 8'h00);
      // timebase rates: /1, /12, baud /2
      for (int i = 0; i < 3; i++) begin
         prescale_select <= ps[i];
         setup(16'h0000, 16'h0000, ctl[i]);
         repeat (kk[i]) @(posedge ref_clk);
         wr(ADDR_CONTROL, 8'h00);
         chk16("rate", ADDR_CNT_LOW, {8'h00, ex[i]});
      end
      setup(16'h0010, 16'h0000, 8'h02);
      u_crb_far_side.fall(1'b0, 2);
      chk16("stopped", ADDR_CNT_LOW, 16'h0010);
      setup(16'hFFFE, 16'hFFF0, 8'h06);
      u_crb_far_side.fall(1'b0, 3);
      chk16("reload", ADDR_CNT_LOW, 16'hFFF1);
      rchk("ovf_flag", ADDR_CONTROL, 8'h86);
      chkb("irq_masked", 1'b0, irq_req);
      irq_enable <= 1'b1;
      repeat (50) @(posedge ref_clk);
      chkb("irq_on", 1'b1, irq_req);
      wr(ADDR_CONTROL, 8'h06);
      rchk("ovf_clear", ADDR_CONTROL, 8'h06);
      chkb("irq_clear", 1'b0, irq_req);
      setup(16'h1234, 16'h0000, 8'h0F);
      u_crb_far_side.fall(1'b1, 1);
      chk16("capture", ADDR_CAP_LOW, 16'h1234);
      rchk("ext_flag", ADDR_CONTROL, 8'h4F);
      chkb("irq_ext", 1'b1, irq_req);
      setup(16'h5678, 16'h0000, 8'h07);
      u_crb_far_side.fall(1'b1, 1);
      chk16("no_capture", ADDR_CAP_LOW, 16'h0000);
      rchk("no_ext", ADDR_CONTROL, 8'h07);
      setup(16'h0005, 16'hABCD, 8'h0E);
      u_crb_far_side.fall(1'b1, 1);
      chk16("trig_reload", ADDR_CNT_LOW, 16'hABCD);
      rchk("trig_flag", ADDR_CONTROL, 8'h4E);
      // baud mode with capture select set
      setup(16'hFFFF, 16'hFFFE, 8'h37);
      rx0 = u_crb_far_side.rx_seen;
      tx0 = u_crb_far_side.tx_seen;
      u_crb_far_side.fall(1'b0, 1);
      u_crb_far_side.ovf_pulse();
      chk16("baud_reload", ADDR_CNT_LOW, 16'hFFFE);
      rchk("baud_noflag", ADDR_CONTROL, 8'h37);
      check8("rx_ticks", 8'h01, u_crb_far_side.rx_seen - rx0);
      check8("tx_ticks", 8'h01, u_crb_far_side.tx_seen - tx0);
      wr(ADDR_CONTROL, 8'h26);
      u_crb_far_side.ovf_pulse();
      check8("rx_sel", 8'h01, u_crb_far_side.rx_seen - rx0);
      check8("tx_sel", 8'h02, u_crb_far_side.tx_seen - tx0);
      wr(ADDR_CONTROL, 8'h16);
      u_crb_far_side.ovf_pulse();
      check8("rx_gen", 8'h02, u_crb_far_side.rx_seen - rx0);
      check8("tx_own", 8'h02, u_crb_far_side.tx_seen - tx0);
      setup(16'h0000, 16'h1111, 8'h3E);
      u_crb_far_side.fall(1'b1, 1);
      rchk("baud_ext", ADDR_CONTROL, 8'h7E);
      tally_and_finish();
   end
endmodule
`default_nettype wire
